// ---- adcpk_consts.svh ----
`ifndef ADCPK_CONSTS_SVH
`define ADCPK_CONSTS_SVH
`define ADCPK_PIN_COUNT 8
`define ADCPK_OFS_PIN0 6'h00
`define ADCPK_OFS_PIN6 6'h18
`define ADCPK_OFS_PIN7 6'h1c
`define ADCPK_OFS_GEN 6'h20
`define ADCPK_DEST_MSB 31
`define ADCPK_DEST_LSB 8
`define ADCPK_PIN_EN_BIT 0
`define ADCPK_DEST_RST 24'h000000
`define ADCPK_GEN_EN_BIT 0
`define ADCPK_GEN_CAL_BIT 1
`define ADCPK_SPP_MSB 15
`define ADCPK_SPP_LSB 8
`define ADCPK_WIDTH_MSB 17
`define ADCPK_WIDTH_LSB 16
`define ADCPK_DROP_BIT 24
`define ADCPK_SPP_RST 8'h01
`define ADCPK_WIDTH_RST 2'h1
`define ADCPK_DROP_RST 1'b1
`define ADCPK_W8 2'h0
`define ADCPK_W16 2'h1
`define ADCPK_W32 2'h3
`define ADCPK_CAL_PULSES 3'h6
`define ADCPK_FIFO_DEPTH 8
`define ADCPK_SAMPLE_W 15
`endif

// ---- adcpk_pkg.sv ----
package adcpk_pkg;
    typedef enum logic [1:0] {ADCPK_IDLE, ADCPK_BYTE, ADCPK_END} adcpk_tx_e;
    typedef struct packed {
        logic [2:0] pin;
        logic [11:0] value;
    } adcpk_sample_s;
endpackage

// ---- adcpk_stream_if.sv ----
interface adcpk_stream_if #(parameter int W = 15);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface

// ---- adcpk_fifo.sv ----
module adcpk_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic nrst_in,
    // Filling and draining sides.
    adcpk_stream_if.snk push,
    adcpk_stream_if.src pop
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_push;
    logic do_pop;

    assign push.ready = (count != DEPTH[AW:0]);
    assign pop.valid = (count != '0);
    assign pop.data = mem[rd_ptr];
    assign do_push = push.valid & push.ready;
    assign do_pop = pop.valid & pop.ready;

    always_ff @(posedge clk_in) begin
        if (do_push) begin
            mem[wr_ptr] <= push.data;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= AW'(wr_ptr + 1'b1);
            end
            if (do_pop) begin
                rd_ptr <= AW'(rd_ptr + 1'b1);
            end
            count <= (AW+1)'(count + (AW+1)'(do_push) - (AW+1)'(do_pop));
        end
    end

    a_fifo_count_bound: assert property (@(posedge clk_in) disable iff (!nrst_in)
        count <= DEPTH) else $error("FIFO count above depth.");
    a_fifo_full_stall: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (count == DEPTH[AW:0]) && !do_pop |=> count == DEPTH[AW:0])
        else $error("Full FIFO lost a word.");
    c_fifo_full: cover property (@(posedge clk_in) disable iff (!nrst_in)
        count == DEPTH[AW:0]);
endmodule // adcpk_fifo

// ---- adcpk_packetizer.sv ----
// Operation
// - Each trigger rising edge starts a 12-bit conversion on the next pin.
// - Registers are reached by full 32-bit reads and writes only.
// - Per-pin bits 31:8 hold the 24-bit destination, reset to zero.
// - Per-pin bit 0 enables that pin, resets zero; bits 7:1 read-only.
// - Dropped-sample bit 24 is set on loss, cleared by read, resets one.
// - Width field 17:16 resets to 1; code 0 sends 8 bits; 2 reserved.
// - Width code 1 sends 16 bits, four low zeros, high byte first.
// - Width code 3 sends 32 bits, twenty low zeros, high byte first.
// - Field 15:8 sets samples per packet before termination; resets to 1.
// - Zero samples per packet keeps packet open until a register access; a sample from another pin also closes it.
// - General bit 1 selects the internal calibration reference; resets zero.
// - General bit 0 enables the converter; per-pin registers then read-only.
// - Six calibration pulses after enabling send nothing; seventh onward deliver.
// - The six-pulse calibration restarts on every enable rise.
`include "adcpk_consts.svh"
module adcpk_packetizer
    import adcpk_pkg::*;
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic nrst_in,
    // Peripheral register port.
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [5:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    output logic [31:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // Sample trigger pin.
    input wire logic trig_in,
    // Converter core.
    output logic conv_start_out,
    output logic [2:0] conv_pin_out,
    output logic conv_cal_out,
    input wire logic conv_valid_in,
    input wire logic [11:0] conv_data_in,
    // Packet output towards the channel-ends.
    output logic pkt_valid_out,
    input wire logic pkt_ready_in,
    output logic [7:0] pkt_data_out,
    output logic pkt_end_out,
    output logic [23:0] pkt_dest_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    logic [23:0] dest [`ADCPK_PIN_COUNT];
    logic [7:0] pin_en;
    logic gen_en;
    logic gen_cal;
    logic [1:0] width;
    logic [7:0] spp;
    logic drop;
    logic gen_en_d;
    logic en_rise;
    logic [2:0] cal_cnt;
    logic cal_done;
    logic trig_s1, trig_s2, trig_s3;
    logic trig_lvl;
    logic trig_rise;
    logic [2:0] last_pin;
    logic [2:0] sel_pin;
    logic drop_evt;
    logic pin_sel;
    logic gen_sel;
    logic [2:0] pin_idx;
    adcpk_tx_e st;
    logic [31:0] sh;
    logic [1:0] byte_idx;
    logic [1:0] last_idx;
    logic pkt_open;
    logic [2:0] pkt_pin;
    logic [7:0] pkt_cnt;
    logic close_req;
    logic need_close;
    logic pop_fire;
    logic byte_fire;
    logic last_byte;
    logic end_fire;
    adcpk_sample_s pop_s;

    adcpk_stream_if #(.W(`ADCPK_SAMPLE_W)) push_if();
    adcpk_stream_if #(.W(`ADCPK_SAMPLE_W)) pop_if();

    adcpk_fifo #(.WIDTH(`ADCPK_SAMPLE_W), .DEPTH(`ADCPK_FIFO_DEPTH)) u_fifo (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .push(push_if.snk),
        .pop(pop_if.src)
    );

    function automatic logic [2:0] adcpk_next_pin(input logic [7:0] en, input logic [2:0] last);
        logic [2:0] p;
        logic found;
        adcpk_next_pin = last;
        found = 1'b0;
        for (int k = 1; k <= 8; k++) begin
            p = 3'(last + 3'(k));
            if (!found && en[p]) begin
                adcpk_next_pin = p;
                found = 1'b1;
            end
        end
    endfunction

    function automatic logic [31:0] adcpk_format(input logic [11:0] v, input logic [1:0] w);
        case (w)
            `ADCPK_W8: adcpk_format = {v[11:4], 24'h000000};
            `ADCPK_W16: adcpk_format = {v, 4'h0, 16'h0000};
            default: adcpk_format = {v, 20'h00000};
        endcase
    endfunction

    function automatic logic [1:0] adcpk_last_idx(input logic [1:0] w);
        case (w)
            `ADCPK_W8: adcpk_last_idx = 2'h0;
            `ADCPK_W16: adcpk_last_idx = 2'h1;
            default: adcpk_last_idx = 2'h3;
        endcase
    endfunction

    // Only whole-word accesses exist on this port, so no byte lanes are decoded.
    assign pin_idx = reg_addr_in[4:2];
    assign pin_sel = (reg_addr_in[5] == 1'b0) && (reg_addr_in[1:0] == 2'h0);
    assign gen_sel = (reg_addr_in == `ADCPK_OFS_GEN);

    // Pin registers are frozen while the converter runs.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < `ADCPK_PIN_COUNT; i++) begin
                dest[i] <= `ADCPK_DEST_RST;
            end
            pin_en <= 8'h00;
        end else if (reg_wr_in && pin_sel && !gen_en) begin
            dest[pin_idx] <= reg_wdata_in[`ADCPK_DEST_MSB:`ADCPK_DEST_LSB];
            pin_en[pin_idx] <= reg_wdata_in[`ADCPK_PIN_EN_BIT];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            gen_en <= 1'b0;
            gen_cal <= 1'b0;
            width <= `ADCPK_WIDTH_RST;
            spp <= `ADCPK_SPP_RST;
        end else if (reg_wr_in && gen_sel) begin
            gen_en <= reg_wdata_in[`ADCPK_GEN_EN_BIT];
            gen_cal <= reg_wdata_in[`ADCPK_GEN_CAL_BIT];
            width <= reg_wdata_in[`ADCPK_WIDTH_MSB:`ADCPK_WIDTH_LSB];
            spp <= reg_wdata_in[`ADCPK_SPP_MSB:`ADCPK_SPP_LSB];
        end
    end

    // A loss in the same cycle as the clearing read still leaves the flag set.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            drop <= `ADCPK_DROP_RST;
        end else if (drop_evt) begin
            drop <= 1'b1;
        end else if (reg_rd_in && gen_sel) begin
            drop <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            reg_rdata_out <= 32'h00000000;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in && pin_sel) begin
                reg_rdata_out <= {dest[pin_idx], 7'h00, pin_en[pin_idx]};
            end else if (reg_rd_in && gen_sel) begin
                reg_rdata_out <= {7'h00, drop, 6'h00, width, spp, 6'h00, gen_cal, gen_en};
            end else if (reg_rd_in) begin
                reg_rdata_out <= 32'h00000000;
            end
        end
    end

    // Trigger pin: three stages, an edge counts once the last two agree.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_s3 <= 1'b0;
            trig_lvl <= 1'b0;
        end else begin
            trig_s1 <= trig_in;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
            if (trig_s2 == trig_s3) begin
                trig_lvl <= trig_s3;
            end
        end
    end
    assign trig_rise = trig_s2 && trig_s3 && !trig_lvl;

    assign en_rise = gen_en && !gen_en_d;
    assign cal_done = (cal_cnt == `ADCPK_CAL_PULSES);
    assign sel_pin = adcpk_next_pin(pin_en, last_pin);
    assign conv_cal_out = gen_cal;

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            conv_start_out <= 1'b0;
            conv_pin_out <= 3'h0;
            last_pin <= 3'h7;
        end else begin
            conv_start_out <= 1'b0;
            if (trig_rise && gen_en) begin
                conv_start_out <= 1'b1;
                conv_pin_out <= sel_pin;
                last_pin <= sel_pin;
            end
        end
    end

    // Calibration pulses are counted on returned conversions, not on edges.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            gen_en_d <= 1'b0;
            cal_cnt <= 3'h0;
        end else begin
            gen_en_d <= gen_en;
            if (en_rise) begin
                cal_cnt <= 3'h0;
            end else if (conv_valid_in && gen_en && !cal_done) begin
                cal_cnt <= 3'(cal_cnt + 3'h1);
            end
        end
    end

    assign push_if.valid = conv_valid_in && gen_en && cal_done && !en_rise;
    assign push_if.data = {conv_pin_out, conv_data_in};
    assign drop_evt = push_if.valid && !push_if.ready;

    assign pop_s = pop_if.data;
    assign need_close = pkt_open && (close_req || (pop_if.valid && pop_s.pin != pkt_pin));
    assign pop_if.ready = (st == ADCPK_IDLE) && !need_close;
    assign pop_fire = pop_if.valid && pop_if.ready;
    assign byte_fire = (st == ADCPK_BYTE) && pkt_ready_in;
    assign last_byte = (byte_idx == last_idx);
    assign end_fire = (st == ADCPK_END) && pkt_ready_in;
    assign pkt_valid_out = (st == ADCPK_BYTE) || (st == ADCPK_END);
    assign pkt_end_out = (st == ADCPK_END);
    assign pkt_data_out = sh[31:24];

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            st <= ADCPK_IDLE;
            sh <= 32'h00000000;
            byte_idx <= 2'h0;
            last_idx <= 2'h0;
            pkt_dest_out <= 24'h000000;
        end else begin
            case (st)
                ADCPK_IDLE: begin
                    if (need_close) begin
                        st <= ADCPK_END;
                    end else if (pop_fire) begin
                        st <= ADCPK_BYTE;
                        sh <= adcpk_format(pop_s.value, width);
                        last_idx <= adcpk_last_idx(width);
                        byte_idx <= 2'h0;
                        pkt_dest_out <= dest[pop_s.pin];
                    end
                end
                ADCPK_BYTE: begin
                    if (pkt_ready_in && !last_byte) begin
                        sh <= {sh[23:0], 8'h00};
                        byte_idx <= 2'(byte_idx + 2'h1);
                    end else if (pkt_ready_in) begin
                        if (spp != 8'h00 && 8'(pkt_cnt + 8'h01) == spp) begin
                            st <= ADCPK_END;
                        end else begin
                            st <= ADCPK_IDLE;
                        end
                    end
                end
                ADCPK_END: begin
                    if (pkt_ready_in) begin
                        st <= ADCPK_IDLE;
                    end
                end
                default: st <= ADCPK_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            pkt_open <= 1'b0;
            pkt_pin <= 3'h0;
            pkt_cnt <= 8'h00;
        end else if (end_fire) begin
            pkt_open <= 1'b0;
            pkt_cnt <= 8'h00;
        end else if (byte_fire && last_byte) begin
            pkt_open <= 1'b1;
            pkt_cnt <= 8'(pkt_cnt + 8'h01);
        end else if (pop_fire) begin
            pkt_pin <= pop_s.pin;
        end
    end

    // An open-ended packet ends when software touches the registers or a sample from another pin arrives.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            close_req <= 1'b0;
        end else if ((reg_wr_in || reg_rd_in) && pkt_open && spp == 8'h00) begin
            close_req <= 1'b1;
        end else if (end_fire) begin
            close_req <= 1'b0;
        end
    end

    a_pin_frozen_run: assert property (gen_en && reg_wr_in && pin_sel |=>
        $stable(pin_en) && dest[$past(pin_idx)] == $past(dest[pin_idx]))
        else $error("Pin register changed while enabled.");
    a_drop_read_clear: assert property (reg_rd_in && gen_sel && !drop_evt |=> !drop)
        else $error("Drop flag survived a read.");
    // A drain in the cycle of the loss may still shrink the queue, so only growth is banned.
    a_drop_on_loss: assert property (drop_evt |=>
        drop && u_fifo.count <= $past(u_fifo.count))
        else $error("Lost sample not flagged.");
    a_cal_no_push: assert property (conv_valid_in && !cal_done |=>
        u_fifo.count <= $past(u_fifo.count))
        else $error("Calibration sample was queued.");
    a_cal_restart: assert property (en_rise |=> cal_cnt == 3'h0 ##0 !push_if.valid)
        else $error("Calibration did not restart.");
    a_start_edge: assert property (trig_rise && gen_en |=> conv_start_out)
        else $error("Trigger edge gave no conversion.");
    a_start_cause: assert property (conv_start_out |-> $past(trig_rise) && $past(gen_en))
        else $error("Conversion without trigger edge.");
    a_pin_enabled: assert property (conv_start_out && pin_en != 8'h00 |->
        pin_en[conv_pin_out])
        else $error("Disabled pin selected.");
    a_w8_byte: assert property (pop_fire && width == `ADCPK_W8 |=>
        pkt_data_out == $past(pop_s.value[11:4]) && last_idx == 2'h0)
        else $error("Eight-bit sample wrong.");
    // The second byte only follows once the first has really been taken.
    a_w16_bytes: assert property (pop_fire && width == `ADCPK_W16 ##1
        pkt_ready_in |-> pkt_data_out == $past(pop_s.value[11:4]) ##1
        pkt_data_out == {$past(pop_s.value[3:0], 2), 4'h0})
        else $error("Sixteen-bit sample wrong.");
    a_w32_length: assert property (pop_fire && width == `ADCPK_W32 |=>
        last_idx == 2'h3 && sh[19:0] == 20'h00000)
        else $error("Thirty-two-bit sample wrong.");
    a_spp_close: assert property (byte_fire && last_byte && spp != 8'h00 &&
        8'(pkt_cnt + 8'h01) == spp |=> pkt_end_out)
        else $error("Packet not ended at count.");
    a_spp_zero_open: assert property (byte_fire && spp == 8'h00 |=> !pkt_end_out)
        else $error("Open packet ended by count.");

    c_full_packet: cover property (end_fire && spp == 8'h02);
    c_drop_seen: cover property (drop_evt);
    c_calib_done: cover property (en_rise ##[1:300] cal_done);
    c_access_close: cover property (close_req ##[1:20] end_fire);
endmodule // adcpk_packetizer

// ---- adcpk_far_model.sv ----
module adcpk_far_model (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic nrst_in,
    // Converter side.
    input wire logic conv_start_in,
    input wire logic [11:0] sample_in,
    output logic conv_valid_out,
    output logic [11:0] conv_data_out,
    // Receiver side.
    input wire logic [1:0] stall_in,
    output logic pkt_ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] busy;
    logic [11:0] held;
    // The result returns two cycles after the start, well before the next one.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            busy <= 2'h0;
            held <= 12'h000;
        end else begin
            busy <= {busy[0], conv_start_in};
            if (conv_start_in) begin
                held <= sample_in;
            end
        end
    end
    assign conv_valid_out = busy[1];
    // Outside the valid cycle the bus shows the inverse, so stale data cannot pass.
    assign conv_data_out = busy[1] ? held : ~held;
    // Mode 0 accepts at once, mode 1 every other cycle, mode 2 stalls completely.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            pkt_ready_out <= 1'b0;
        end else begin
            pkt_ready_out <= (stall_in == 2'h0) | ((stall_in == 2'h1) & ~pkt_ready_out);
        end
    end
endmodule // adcpk_far_model

// ---- tb_adcpk_packetizer.sv ----
`include "adcpk_consts.svh"
module tb_adcpk_packetizer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, nrst_in = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, trig = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [11:0] sample = 12'h000, conv_data;
    logic [1:0] stall = 2'h0;
    logic [2:0] conv_pin;
    logic [7:0] pkt_data;
    logic [23:0] pkt_dest;
    logic reg_rvalid, conv_start, conv_cal, conv_valid, pkt_valid, pkt_ready, pkt_end;
    logic [32:0] rd_q[$], pk_q[$];
    logic [23:0] dest [8];
    logic [7:0] en_mask = 8'h00, spp = 8'h01;
    logic [1:0] width = 2'h1;
    logic [2:0] last_pin = 3'h7, open_pin = 3'h0;
    logic gen_en = 1'b0, gen_cal = 1'b0, pk_open = 1'b0, ignore = 1'b0;
    int error_cnt = 0, samples_checked = 0, cal_cnt = 0, pk_cnt = 0, cyc = 0;
    logic [1:0] wlist [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
    adcpk_packetizer u_adcpk_packetizer (.clk_in(clk_in), .nrst_in(nrst_in),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata), .reg_rvalid_out(reg_rvalid),
        .trig_in(trig), .conv_start_out(conv_start), .conv_pin_out(conv_pin),
        .conv_cal_out(conv_cal), .conv_valid_in(conv_valid), .conv_data_in(conv_data),
        .pkt_valid_out(pkt_valid), .pkt_ready_in(pkt_ready), .pkt_data_out(pkt_data),
        .pkt_end_out(pkt_end), .pkt_dest_out(pkt_dest));
    adcpk_far_model u_adcpk_far_model (.clk_in(clk_in), .nrst_in(nrst_in),
        .conv_start_in(conv_start), .sample_in(sample), .conv_valid_out(conv_valid),
        .conv_data_out(conv_data), .stall_in(stall), .pkt_ready_out(pkt_ready));
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    function automatic logic [31:0] gv(input logic drop);
        return {7'h00, drop, 6'h00, width, spp, 6'h00, gen_cal, gen_en};
    endfunction
    function automatic void push_end();
        pk_q.push_back({1'b1, 32'h0});
        pk_open = 1'b0;
        pk_cnt = 0;
    endfunction
    // An open endless packet is closed by any register access.
    function automatic void close_open();
        if (pk_open && spp == 8'h00) push_end();
    endfunction
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        close_open();
        if (a == `ADCPK_OFS_GEN) begin
            if (d[0] && !gen_en) cal_cnt = 0;
            {width, spp, gen_cal, gen_en} = {d[17:8], d[1:0]};
        end else if (!gen_en) begin
            dest[a[4:2]] = d[31:8];
            en_mask[a[4:2]] = d[0];
        end
        @(posedge clk_in);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        reg_rd <= 1'b1;
        reg_addr <= a;
        rd_q.push_back({1'b0, exp});
        close_open();
        @(posedge clk_in);
        reg_rd <= 1'b0;
    endtask
    task automatic trg();
        logic [11:0] v;
        logic [2:0] p;
        v = 12'($urandom);
        p = last_pin;
        for (int i = 0; i < 8; i++) begin
            p = p + 3'h1;
            if (en_mask[p]) break;
        end
        last_pin = p;
        if (cal_cnt < 6) begin
            cal_cnt++;
        end else begin
            if (pk_open && p != open_pin) push_end();
            pk_open = 1'b1;
            open_pin = p;
            pk_q.push_back({1'b0, dest[p], v[11:4]});
            if (width != `ADCPK_W8) pk_q.push_back({1'b0, dest[p], v[3:0], 4'h0});
            if (width[1]) pk_q.push_back({1'b0, dest[p], 8'h00});
            if (width[1]) pk_q.push_back({1'b0, dest[p], 8'h00});
            pk_cnt++;
            if (spp != 8'h00 && pk_cnt == int'(spp)) push_end();
        end
        @(posedge clk_in);
        sample <= v;
        trig <= 1'b1;
        repeat (6) @(posedge clk_in);
        trig <= 1'b0;
        repeat (6) @(posedge clk_in);
    endtask
    task automatic drain();
        for (int i = 0; i < 400 && pk_q.size() != 0; i++) @(posedge clk_in);
        repeat (4) @(posedge clk_in);
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
        if (reg_rvalid === 1'b1) begin
            chk("register", {1'b0, reg_rdata}, rd_q.pop_front());
        end
        if (pkt_valid === 1'b1 && pkt_ready === 1'b1 && !ignore) begin
            chk("packet token", pkt_end ? {1'b1, 32'h0} : {1'b0, pkt_dest, pkt_data},
                pk_q.size() != 0 ? pk_q.pop_front() : 33'h0);
        end
    end
    initial begin
        logic [31:0] seed;
        seed = $urandom(4576);
        repeat (12) @(posedge clk_in);
        nrst_in <= 1'b1;
        rd(`ADCPK_OFS_GEN, gv(1'b1));
        rd(`ADCPK_OFS_GEN, gv(1'b0));
        rd(`ADCPK_OFS_PIN6, 32'h0);
        rd(6'h24, 32'h0);
        $display("reset values done");
        // Pin settings are only programmed while the converter is off.
        wr(`ADCPK_OFS_PIN6, {24'($urandom), 7'h7f, 1'b1});
        wr(`ADCPK_OFS_PIN7, {24'($urandom), 7'h55, 1'b1});
        rd(`ADCPK_OFS_PIN6, {dest[6], 8'h01});
        rd(`ADCPK_OFS_PIN7, {dest[7], 8'h01});
        wr(`ADCPK_OFS_GEN, 32'h0001_0102);
        repeat (2) @(posedge clk_in);
        chk("calibration select", {32'h0, conv_cal}, 33'h1);
        // Calibration is cleared in the same write that enables, so no conversion runs with the reference selected.
        wr(`ADCPK_OFS_GEN, 32'h0001_0101);
        wr(`ADCPK_OFS_PIN6, 32'h0);
        rd(`ADCPK_OFS_PIN6, {dest[6], 8'h01});
        $display("register access done");
        stall <= 2'h1;
        repeat (12) trg();
        drain();
        $display("two pin stream done");
        foreach (wlist[i]) begin
            stall <= 2'($urandom % 2);
            wr(`ADCPK_OFS_GEN, 32'h0);
            wr(`ADCPK_OFS_PIN7, 32'h0);
            wr(`ADCPK_OFS_GEN, {14'h0, wlist[i], 8'h02, 8'h01});
            repeat (10) trg();
            drain();
        end
        $display("width codes done");
        wr(`ADCPK_OFS_GEN, 32'h0);
        wr(`ADCPK_OFS_GEN, 32'h0000_0001);
        repeat (9) trg();
        drain();
        rd(`ADCPK_OFS_GEN, gv(1'b0));
        drain();
        $display("endless packet done");
        wr(`ADCPK_OFS_GEN, 32'h0);
        wr(`ADCPK_OFS_GEN, 32'h0003_0101);
        repeat (6) trg();
        stall <= 2'h2;
        ignore = 1'b1;
        repeat (12) trg();
        rd(`ADCPK_OFS_GEN, gv(1'b1));
        stall <= 2'h0;
        repeat (300) @(posedge clk_in);
        pk_q.delete();
        pk_open = 1'b0;
        pk_cnt = 0;
        ignore = 1'b0;
        rd(`ADCPK_OFS_GEN, gv(1'b0));
        repeat (4) @(posedge clk_in);
        $display("dropped samples done");
        chk("leftover tokens", 33'(pk_q.size()), 33'h0);
        end_of_test();
    end
endmodule // tb_adcpk_packetizer
